//--- rtl/mapper_common_control_regs.svh
// register offsets, field positions and reset values of the common control bank
`ifndef MAPPER_COMMON_CONTROL_REGS_SVH
`define MAPPER_COMMON_CONTROL_REGS_SVH
// printed offsets are not all multiples of four: these are word indices
`define IDX_RESET_AND_LATCH_CONTROL 12'h000
`define IDX_LOOPBACK_TEST_CONTROL 12'h001
`define IDX_IRQ_PIN_AND_PULLUP_CONFIG 12'h003
`define IDX_SILICON_REVISION 12'h004
`define IDX_MGMT_STATION_ADDRESS_REG 12'h005
`define IDX_MGMT_MIRROR 12'h006
`define BIT_GLOBAL_RESET 0
`define BIT_STATE_RESET 2
`define BIT_COUNTER_SNAPSHOT 3
`define BIT_PRE_FRAMER_LOOP 0
`define BIT_POST_FRAMER_LOOP 1
`define BIT_MEDIA_LOOP 2
`define BIT_CLOCK_PULLUP_OFF 4
`define BIT_DATA_PULLUP_OFF 5
`define BIT_MGMT_LOOPBACK 14
`define RST_RESET_AND_LATCH 8'h00
`define RST_LOOPBACK_TEST 8'h00
`define RST_IRQ_PIN_CONFIG 8'h00
`define RST_STATION_ADDRESS 5'h1B
// narrow views of the reset values, sized to the fields they restore
`define RST_RESET_AND_LATCH_BIT_STATE 1'h0
`define RST_LOOPBACK_TEST_LOW 3'h0
`define RST_IRQ_PIN_CONFIG_MODE 2'h0
`define MDIO_ADDR_WIDTH 5
`define REG_DATA_WIDTH 8
`endif

//--- rtl/mapper_common_pkg.sv
// types shared by the common control bank
package mapper_common_pkg;
  typedef enum logic [1:0] {
    irq_open_drain_low,
    irq_open_source_high,
    irq_driven_low,
    irq_driven_high
  } irq_drive_mode_t;
endpackage : mapper_common_pkg

//--- rtl/irq_pin_driver.sv
// interrupt pin driver: maps the drive-mode code onto pin level and enable
`timescale 1ns/1ns
`default_nettype none
module irq_pin_driver (
  input wire logic irq_active,
  input wire mapper_common_pkg::irq_drive_mode_t drive_mode,
  output logic irq_pin_out,
  output logic irq_pin_oe
);
  // open modes only drive while asserted so the pin can be wire-ored
  always_comb begin
    irq_pin_out = 1'b0;
    irq_pin_oe = 1'b0;
    unique case (drive_mode)
      mapper_common_pkg::irq_open_drain_low: begin
        irq_pin_out = 1'b0;
        irq_pin_oe = irq_active;
      end
      mapper_common_pkg::irq_open_source_high: begin
        irq_pin_out = 1'b1;
        irq_pin_oe = irq_active;
      end
      mapper_common_pkg::irq_driven_low: begin
        irq_pin_out = ~irq_active;
        irq_pin_oe = 1'b1;
      end
      mapper_common_pkg::irq_driven_high: begin
        irq_pin_out = irq_active;
        irq_pin_oe = 1'b1;
      end
    endcase
  end
endmodule : irq_pin_driver
`default_nettype wire

//--- rtl/mapper_common_control_regs.sv
// common control and identification register bank, APB slave
//
// Added by the designer: the APB interface to the registers.
`include "mapper_common_control_regs.svh"
`timescale 1ns/1ns
`default_nettype none
// How it works
// - global reset restores registers, self-clears
// - state reset holds machines while its bit is set, keeps registers
// - media loopback steers MII transmit to receive
// - media loopback only applies in PHY mode
// - management loopback bit ORs with ours
// - post-framer line loop output
// - pre-framer line loop output
// - data pull-up off follows its bit
// - clock pull-up off follows its bit
// - drive field selects interrupt pin behaviour
// - code 01 gives open-source active high
// - revision read-only, mirrors management register three
// - station address resets to 0x1B
// - MDIO match compares frame address with ours
// - hard or soft reset restores defaults
module mapper_common_control_regs #(
  parameter logic [3:0] SILICON_REV = 4'hA, // arbitrary value
  parameter int MII_WIDTH = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [13:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic phy_mode,
  input wire logic mgmt_loopback_bit,
  input wire logic [`MDIO_ADDR_WIDTH-1:0] mdio_frame_addr,
  output logic mdio_addr_match,
  input wire logic [MII_WIDTH-1:0] mii_tx_data,
  input wire logic mii_tx_en,
  input wire logic [MII_WIDTH-1:0] rx_path_data,
  input wire logic rx_path_dv,
  output logic [MII_WIDTH-1:0] mii_rx_data,
  output logic mii_rx_dv,
  output logic line_loop_post_framer_en,
  output logic line_loop_pre_framer_en,
  output logic eeprom_data_pullup_off,
  output logic eeprom_clock_pullup_off,
  input wire logic irq_active,
  output logic irq_pin_out,
  output logic irq_pin_oe,
  output logic state_machine_reset,
  output logic counter_snapshot_cmd,
  output logic [3:0] silicon_revision_field,
  output logic [`MDIO_ADDR_WIDTH-1:0] mgmt_station_address
);
  // ==========================================================
  // bus decode
  logic [11:0] word_index;
  logic wr_en;
  logic rd_en;
  logic idx_hit;
  assign word_index = paddr[13:2];
  assign wr_en = psel && penable && pwrite && pstrb[0];
  assign rd_en = psel && penable && !pwrite;
  // zero-wait slave; unmapped words answer with an error
  assign pready = 1'b1;
  always_comb begin
    unique case (word_index)
      `IDX_RESET_AND_LATCH_CONTROL,
      `IDX_LOOPBACK_TEST_CONTROL,
      `IDX_IRQ_PIN_AND_PULLUP_CONFIG,
      `IDX_SILICON_REVISION,
      `IDX_MGMT_STATION_ADDRESS_REG: idx_hit = 1'b1;
      default: idx_hit = 1'b0;
    endcase
  end
  assign pslverr = psel && penable && !idx_hit;

  // ==========================================================
  // register state
  logic global_reset_pulse;
  logic state_reset_bit;
  logic snapshot_bit;
  logic [2:0] loop_bits;
  logic [1:0] pullup_bits;
  mapper_common_pkg::irq_drive_mode_t drive_mode;
  logic [`MDIO_ADDR_WIDTH-1:0] station_addr;
  logic [31:0] read_word;
  logic next_global_reset_pulse;
  logic next_state_reset_bit;
  logic next_snapshot_bit;
  logic [2:0] next_loop_bits;
  logic [1:0] next_pullup_bits;
  mapper_common_pkg::irq_drive_mode_t next_drive_mode;
  logic [`MDIO_ADDR_WIDTH-1:0] next_station_addr;
  logic [31:0] next_read_word;

  // writes; a pending global reset overrides everything for one cycle
  always_comb begin
    next_global_reset_pulse = 1'b0; // self-clears the cycle after
    next_state_reset_bit = state_reset_bit;
    next_snapshot_bit = snapshot_bit;
    next_loop_bits = loop_bits;
    next_pullup_bits = pullup_bits;
    next_drive_mode = drive_mode;
    next_station_addr = station_addr;
    if (wr_en) begin
      unique case (word_index)
        `IDX_RESET_AND_LATCH_CONTROL: begin
          next_global_reset_pulse = pwdata[`BIT_GLOBAL_RESET];
          next_state_reset_bit = pwdata[`BIT_STATE_RESET];
          next_snapshot_bit = pwdata[`BIT_COUNTER_SNAPSHOT];
        end
        `IDX_LOOPBACK_TEST_CONTROL: begin
          next_loop_bits = pwdata[`BIT_MEDIA_LOOP:`BIT_PRE_FRAMER_LOOP];
        end
        `IDX_IRQ_PIN_AND_PULLUP_CONFIG: begin
          next_pullup_bits = pwdata[`BIT_DATA_PULLUP_OFF:`BIT_CLOCK_PULLUP_OFF];
          next_drive_mode = mapper_common_pkg::irq_drive_mode_t'(pwdata[1:0]);
        end
        `IDX_MGMT_STATION_ADDRESS_REG: begin
          next_station_addr = pwdata[`MDIO_ADDR_WIDTH-1:0];
        end
        default: begin
        end
      endcase
    end
    // soft reset returns all writable fields to defaults
    if (global_reset_pulse) begin
      next_state_reset_bit = `RST_RESET_AND_LATCH_BIT_STATE;
      next_snapshot_bit = 1'b0;
      next_loop_bits = `RST_LOOPBACK_TEST_LOW;
      next_pullup_bits = 2'h0;
      next_drive_mode = mapper_common_pkg::irq_drive_mode_t'(`RST_IRQ_PIN_CONFIG_MODE);
      next_station_addr = `RST_STATION_ADDRESS;
    end
  end

  // read mux; reserved bits stay zero
  always_comb begin
    next_read_word = 32'h0000_0000;
    if (rd_en) begin
      unique case (word_index)
        `IDX_RESET_AND_LATCH_CONTROL: begin
          next_read_word[`BIT_STATE_RESET] = state_reset_bit;
          next_read_word[`BIT_COUNTER_SNAPSHOT] = snapshot_bit;
        end
        `IDX_LOOPBACK_TEST_CONTROL: begin
          next_read_word[2:0] = loop_bits;
        end
        `IDX_IRQ_PIN_AND_PULLUP_CONFIG: begin
          next_read_word[`BIT_DATA_PULLUP_OFF:`BIT_CLOCK_PULLUP_OFF] = pullup_bits;
          next_read_word[1:0] = drive_mode;
        end
        `IDX_SILICON_REVISION: begin
          next_read_word[3:0] = SILICON_REV;
        end
        `IDX_MGMT_STATION_ADDRESS_REG: begin
          next_read_word[`MDIO_ADDR_WIDTH-1:0] = station_addr;
        end
        default: begin
        end
      endcase
    end
  end

  // hardware reset sets defaults
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      global_reset_pulse <= 1'b0;
      state_reset_bit <= 1'b0;
      snapshot_bit <= 1'b0;
      loop_bits <= 3'h0;
      pullup_bits <= 2'h0;
      drive_mode <= mapper_common_pkg::irq_open_drain_low;
      station_addr <= `RST_STATION_ADDRESS;
      read_word <= 32'h0000_0000;
    end else begin
      global_reset_pulse <= next_global_reset_pulse;
      state_reset_bit <= next_state_reset_bit;
      snapshot_bit <= next_snapshot_bit;
      loop_bits <= next_loop_bits;
      pullup_bits <= next_pullup_bits;
      drive_mode <= next_drive_mode;
      station_addr <= next_station_addr;
      read_word <= next_read_word;
    end
  end
  // read data is combinational in the access phase; the registered copy holds it for one cycle afterwards, then reads zero
  assign prdata = rd_en ? next_read_word : read_word;

  // ==========================================================
  // snapshot edge detect: a held bit latches counters only once
  logic snapshot_seen;
  logic next_snapshot_seen;
  always_comb begin
    next_snapshot_seen = snapshot_bit;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      snapshot_seen <= 1'b0;
    end else begin
      snapshot_seen <= next_snapshot_seen;
    end
  end
  assign counter_snapshot_cmd = snapshot_bit && !snapshot_seen;

  // state machines held while the bit is set or a soft reset runs
  assign state_machine_reset = state_reset_bit || global_reset_pulse;

  // ==========================================================
  // loopback and pin control
  logic media_loop_active;
  assign media_loop_active = phy_mode
    && (loop_bits[`BIT_MEDIA_LOOP] || mgmt_loopback_bit);
  logic [MII_WIDTH-1:0] next_mii_rx_data;
  logic next_mii_rx_dv;
  // mux is registered to keep the receive bus glitch-free
  always_comb begin
    next_mii_rx_data = media_loop_active ? mii_tx_data : rx_path_data;
    next_mii_rx_dv = media_loop_active ? mii_tx_en : rx_path_dv;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mii_rx_data <= '0;
      mii_rx_dv <= 1'b0;
    end else begin
      mii_rx_data <= next_mii_rx_data;
      mii_rx_dv <= next_mii_rx_dv;
    end
  end
  // line loops assume equal receive and transmit line clocks
  assign line_loop_post_framer_en = loop_bits[`BIT_POST_FRAMER_LOOP];
  assign line_loop_pre_framer_en = loop_bits[`BIT_PRE_FRAMER_LOOP];
  assign eeprom_data_pullup_off = pullup_bits[1];
  assign eeprom_clock_pullup_off = pullup_bits[0];
  assign silicon_revision_field = SILICON_REV;
  assign mgmt_station_address = station_addr;
  assign mdio_addr_match = (mdio_frame_addr == station_addr);

  irq_pin_driver u_irq_pin_driver (
    .irq_active(irq_active),
    .drive_mode(drive_mode),
    .irq_pin_out(irq_pin_out),
    .irq_pin_oe(irq_pin_oe)
  );

  // ==========================================================
  // checks
  soft_reset_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
    global_reset_pulse |=> !global_reset_pulse) else $error("global reset stuck");
  soft_reset_addr_a: assert property (@(posedge pclk) disable iff (!presetn)
    global_reset_pulse |=> station_addr == `RST_STATION_ADDRESS)
    else $error("address not restored");
  snapshot_once_a: assert property (@(posedge pclk) disable iff (!presetn)
    counter_snapshot_cmd |=> !counter_snapshot_cmd) else $error("snapshot repeats");
  media_loop_a: assert property (@(posedge pclk) disable iff (!presetn)
    (phy_mode && loop_bits[`BIT_MEDIA_LOOP]) |=> mii_rx_data == $past(mii_tx_data))
    else $error("loopback data wrong");
  mac_no_loop_a: assert property (@(posedge pclk) disable iff (!presetn)
    !phy_mode |=> mii_rx_data == $past(rx_path_data)) else $error("loop in mac mode");
  mgmt_loop_a: assert property (@(posedge pclk) disable iff (!presetn)
    (phy_mode && mgmt_loopback_bit) |=> mii_rx_dv == $past(mii_tx_en))
    else $error("mgmt loopback ignored");
  state_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
    state_reset_bit |-> state_machine_reset) else $error("state reset missing");
  irq_open_drain_a: assert property (@(posedge pclk) disable iff (!presetn)
    (drive_mode == mapper_common_pkg::irq_open_drain_low && !irq_active) |-> !irq_pin_oe)
    else $error("open drain drives idle");
  irq_source_a: assert property (@(posedge pclk) disable iff (!presetn)
    (drive_mode == mapper_common_pkg::irq_open_source_high && irq_active)
    |-> irq_pin_oe && irq_pin_out) else $error("open source wrong");
  addr_match_a: assert property (@(posedge pclk) disable iff (!presetn)
    mdio_addr_match |-> mdio_frame_addr == station_addr) else $error("false match");
  reserved_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
    (rd_en && word_index == `IDX_SILICON_REVISION) |-> prdata[31:4] == 28'h0)
    else $error("reserved bits set");
endmodule : mapper_common_control_regs
`default_nettype wire

//--- bench/host_apb_model.sv
// host processor model: apb master issuing register transfers
`timescale 1ns/1ns
`default_nettype none
module host_apb_model (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [13:0] paddr,
  output logic [31:0] pwdata,
  output logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ==========================================
  // bus idle at time zero
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 14'h0;
    pwdata = 32'h0;
    pstrb = 4'h0;
  end
  // one transfer; line loops only set here with one shared line clock
  // station address used as given by the bench
  task automatic xfer(input logic w, input logic [11:0] idx, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= d;
    pstrb <= 4'hF;
    penable <= 1'b0;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    // no wait count assumed, bounded against a hung slave
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 100);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : host_apb_model
`default_nettype wire

//--- bench/tb.sv
// self-checking bench for the common control register bank
`include "mapper_common_control_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module tb;
  localparam logic [3:0] REV = 4'h5; // arbitrary value
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, errv;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, rdv;
  logic [3:0] pstrb, tx_d, rx_d, mii_rx_data, rev;
  logic phy_mode, mgmt_lb, irq_active, mii_tx_en, rx_path_dv, mii_rx_dv, match;
  logic post_lb, pre_lb, sda_off, scl_off, irq_out, irq_oe, sm_rst, snap;
  logic [4:0] frame_addr, sta;
  int n_fail = 0, samples_checked = 0;
  host_apb_model host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  mapper_common_control_regs #(.SILICON_REV(REV), .MII_WIDTH(4)) uut (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .phy_mode(phy_mode), .mgmt_loopback_bit(mgmt_lb), .mdio_frame_addr(frame_addr),
    .mdio_addr_match(match), .mii_tx_data(tx_d), .mii_tx_en(mii_tx_en),
    .rx_path_data(rx_d), .rx_path_dv(rx_path_dv), .mii_rx_data(mii_rx_data),
    .mii_rx_dv(mii_rx_dv), .line_loop_post_framer_en(post_lb),
    .line_loop_pre_framer_en(pre_lb), .eeprom_data_pullup_off(sda_off),
    .eeprom_clock_pullup_off(scl_off), .irq_active(irq_active), .irq_pin_out(irq_out),
    .irq_pin_oe(irq_oe), .state_machine_reset(sm_rst), .counter_snapshot_cmd(snap),
    .silicon_revision_field(rev), .mgmt_station_address(sta));
  // ==========================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [11:0] i, input logic [31:0] d);
    host.xfer(1'b1, i, d, rdv, errv);
  endtask : wr
  task automatic rc(input logic [11:0] i, input logic [31:0] e);
    host.xfer(1'b0, i, 32'h0, rdv, errv);
    chk(rdv, e);
  endtask : rc
  // counts cycles a pulse output is high, sel 0 state reset, 1 snapshot
  task automatic pulses(input logic sel, input int exp);
    int n;
    n = 0;
    repeat (4) begin
      @(negedge pclk);
      n += sel ? snap : sm_rst;
    end
    chk(32'(n), 32'(exp));
  endtask : pulses
  // ==========================================
  // scenarios
  task automatic t_defaults;
    rc(`IDX_RESET_AND_LATCH_CONTROL, 32'h0);
    rc(`IDX_LOOPBACK_TEST_CONTROL, 32'h0);
    rc(`IDX_IRQ_PIN_AND_PULLUP_CONFIG, 32'h0);
    rc(`IDX_MGMT_STATION_ADDRESS_REG, 32'h1B);
    wr(`IDX_SILICON_REVISION, 32'hFF);
    rc(`IDX_SILICON_REVISION, {28'h0, REV});
    chk(32'(rev), 32'(REV));
    host.xfer(1'b0, 12'h002, 32'h0, rdv, errv);
    chk({31'h0, errv}, 32'h1);
  endtask : t_defaults
  task automatic mii(input logic p, input logic m, input logic lp);
    @(posedge pclk);
    phy_mode <= p;
    mgmt_lb <= m;
    tx_d <= 4'hA;
    mii_tx_en <= 1'b1;
    rx_d <= 4'h3;
    rx_path_dv <= 1'b0;
    @(posedge pclk);
    @(negedge pclk);
    chk(32'({mii_rx_dv, mii_rx_data}), lp ? 32'h1A : 32'h03);
  endtask : mii
  task automatic t_loop;
    for (int i = 0; i < 4; i++) begin
      wr(`IDX_LOOPBACK_TEST_CONTROL, 32'hF8 | i);
      @(negedge pclk);
      chk(32'({post_lb, pre_lb}), 32'(i));
      rc(`IDX_LOOPBACK_TEST_CONTROL, 32'(i));
    end
    mii(1'b1, 1'b0, 1'b0);
    mii(1'b1, 1'b1, 1'b1);
    wr(`IDX_LOOPBACK_TEST_CONTROL, 32'h4);
    mii(1'b1, 1'b0, 1'b1);
    mii(1'b0, 1'b1, 1'b0);
  endtask : t_loop
  task automatic t_irq;
    logic [1:0] m;
    for (int i = 0; i < 8; i++) begin
      m = 2'(i >> 1);
      wr(`IDX_IRQ_PIN_AND_PULLUP_CONFIG, 32'hCC | 32'(m) * 32'h11);
      irq_active <= i[0];
      @(negedge pclk);
      chk(32'({sda_off, scl_off}), 32'(m));
      chk(32'({irq_oe, irq_out}), 32'({m[1] | i[0], m[1] ? ~(m[0] ^ i[0]) : m[0]}));
    end
    rc(`IDX_IRQ_PIN_AND_PULLUP_CONFIG, 32'h33);
  endtask : t_irq
  task automatic t_addr;
    wr(`IDX_MGMT_STATION_ADDRESS_REG, 32'hE5);
    rc(`IDX_MGMT_STATION_ADDRESS_REG, 32'h05);
    frame_addr <= 5'h05;
    @(negedge pclk);
    chk({27'h0, sta, match}, 32'hB);
    @(posedge pclk);
    frame_addr <= 5'h1B;
    @(negedge pclk);
    chk({31'h0, match}, 32'h0);
  endtask : t_addr
  task automatic t_ctl;
    wr(`IDX_RESET_AND_LATCH_CONTROL, 32'h08);
    pulses(1'b1, 1);
    wr(`IDX_LOOPBACK_TEST_CONTROL, 32'h3);
    wr(`IDX_RESET_AND_LATCH_CONTROL, 32'h04);
    @(negedge pclk);
    chk({31'h0, sm_rst}, 32'h1);
    rc(`IDX_LOOPBACK_TEST_CONTROL, 32'h3);
    wr(`IDX_RESET_AND_LATCH_CONTROL, 32'h0);
    pulses(1'b0, 0);
    wr(`IDX_IRQ_PIN_AND_PULLUP_CONFIG, 32'h31);
    wr(`IDX_RESET_AND_LATCH_CONTROL, 32'h01);
    pulses(1'b0, 1);
    rc(`IDX_RESET_AND_LATCH_CONTROL, 32'h0);
    rc(`IDX_LOOPBACK_TEST_CONTROL, 32'h0);
    rc(`IDX_IRQ_PIN_AND_PULLUP_CONFIG, 32'h0);
    rc(`IDX_MGMT_STATION_ADDRESS_REG, 32'h1B);
    chk(32'({post_lb, pre_lb, sda_off, scl_off}), 32'h0);
  endtask : t_ctl
  task automatic print_verdict;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict
  // ==========================================
  // clock, reset, sequence and watchdog
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end
  initial begin
    presetn = 1'b0;
    {phy_mode, mgmt_lb, irq_active, mii_tx_en, rx_path_dv} = 5'h0;
    {tx_d, rx_d} = 8'h0;
    frame_addr = 5'h0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_defaults();
    t_loop();
    t_irq();
    t_addr();
    t_ctl();
    print_verdict();
  end
  // ~150 cycles expected, generous bound
  initial begin
    #400000;
    n_fail++;
    print_verdict();
  end
endmodule : tb
`default_nettype wire
